// File: verilog/rsic_pkg.sv
// Shared constants, register map and helpers of the strength readout block
package rsic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int unsigned CLK_HZ  = 100_000_000;
  // Filter clock at divider setting zero: twice the widest channel bandwidth
  localparam int unsigned BASE_HZ = 614_400;
  localparam int          NCO_W   = 24;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((64'(BASE_HZ) << NCO_W) / 64'(CLK_HZ));
  localparam int unsigned CYC_LO  = CLK_HZ / BASE_HZ;
  localparam int unsigned CYC_HI  = CYC_LO + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int AMP_W   = 27;
  localparam int STR_W   = 7;
  localparam int TRIM_W  = 7;
  localparam int GAIN_W  = 5;
  localparam int AVG_W   = 2;
  localparam int DIV_W   = 5;
  localparam int UPD_W   = 16;
  localparam int SUM_W   = AMP_W + 4;

  localparam logic [STR_W-1:0] STR_MAX = 7'h6a;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_STRENGTH = 8'h04;
  localparam logic [7:0] OFS_PHASE    = 8'h08;
  localparam logic [7:0] OFS_GAIN     = 8'h0c;
  localparam logic [7:0] OFS_MAXGAIN  = 8'h10;
  localparam logic [7:0] OFS_UPDATES  = 8'h14;

  // Field positions
  localparam int CFG_AVG_LSB   = 0;
  localparam int CFG_DIV_LSB   = 8;
  localparam int STR_FRESH_BIT = 7;

  // Reset values
  localparam logic [AVG_W-1:0]  AVG_RST     = 2'h0;
  localparam logic [DIV_W-1:0]  DIV_RST     = 5'h00;
  localparam logic [TRIM_W-1:0] TRIM_RST    = 7'h00;
  localparam logic [GAIN_W-1:0] MAXGAIN_RST = 5'h00;

  // Index of the last sample of an averaging run
  function automatic logic [3:0] avg_last(input logic [AVG_W-1:0] sel);
    return 4'((5'h02 << sel) - 5'h01);
  endfunction

endpackage

// File: verilog/rsic_meas_if.sv
// Averaged amplitude to strength conversion channel
`timescale 1ns/1ps
interface rsic_meas_if;
  import rsic_pkg::*;
  logic [AMP_W-1:0] mean;
  logic             mean_valid;
  logic [STR_W-1:0] strength;
  logic             strength_valid;
  modport conv (input mean, input mean_valid, output strength, output strength_valid);
  modport user (output mean, output mean_valid, input strength, input strength_valid);
endinterface

// File: verilog/rsic_tick_gen.sv
// Filter clock strobe generator: fractional base rate divided by the decimation
`timescale 1ns/1ps
module rsic_tick_gen (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Decimation setting
  input  wire logic [rsic_pkg::DIV_W-1:0] div_sel,
  // One-cycle strobe at the filter output rate
  output logic                           filter_tick
);
  import rsic_pkg::*;

  logic [NCO_W-1:0] nco_r;
  logic [DIV_W-1:0] cnt_r;
  logic             filter_tick_r;
  logic [NCO_W:0]   nco_sum;
  logic             base_tick;
  logic             fire;

  assign nco_sum     = {1'b0, nco_r} + {1'b0, NCO_INC};
  assign base_tick   = nco_sum[NCO_W];
  assign fire        = base_tick && (cnt_r >= div_sel); // [R5]
  assign filter_tick = filter_tick_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nco_r         <= '0;
      cnt_r         <= '0;
      filter_tick_r <= 1'b0;
    end else begin
      nco_r         <= nco_sum[NCO_W-1:0];
      filter_tick_r <= fire;
      if (base_tick) begin
        cnt_r <= fire ? '0 : cnt_r + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period check helpers
  logic [15:0]      gap_r;
  logic             armed_r;
  logic             moved_r;
  logic [DIV_W-1:0] div_q_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_r   <= 16'h0000;
      armed_r <= 1'b0;
      moved_r <= 1'b1;
      div_q_r <= '0;
    end else begin
      gap_r   <= filter_tick_r ? 16'h0001 : gap_r + 16'h0001;
      armed_r <= armed_r | filter_tick_r;
      moved_r <= filter_tick_r ? 1'b0 : (moved_r | (div_sel != div_q_r));
      div_q_r <= div_sel;
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (!rst_b)
      (filter_tick_r && armed_r && !moved_r && (div_sel == div_q_r)) |->
        (gap_r >= 16'(CYC_LO * (div_sel + 1)) && gap_r <= 16'(CYC_HI * (div_sel + 1)));
  endproperty
  a_tick_period: assert property (p_tick_period) // [R5]
    else $error("filter strobe period off the divided base rate");

endmodule

// File: verilog/rsic_log4.sv
// Registered conversion of averaged amplitude to four times its base-two log
`timescale 1ns/1ps
module rsic_log4 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Conversion channel
  rsic_meas_if.conv meas
);
  import rsic_pkg::*;

  // Integer part from the leading one, two fraction bits from below it
  function automatic logic [STR_W-1:0] log4(input logic [AMP_W-1:0] m);
    logic [4:0] p;
    logic [1:0] f;
    logic [7:0] v;
    p = 5'h00;
    f = 2'h0;
    for (int i = 1; i < AMP_W; i++) begin
      if (m[i]) begin
        p = 5'(i);
      end
    end
    if (p >= 5'h02) begin
      f = m[p-5'h01 -: 2];
    end else if (p == 5'h01) begin
      f = {m[0], 1'b0};
    end
    v = {1'b0, p, 2'b00} + {6'h00, f}; // [R2] [R3]
    return (v > {1'b0, STR_MAX}) ? STR_MAX : v[STR_W-1:0]; // [R1]
  endfunction

  logic [STR_W-1:0] strength_r;
  logic             valid_r;
  logic [AMP_W-1:0] last_mean_r;

  assign meas.strength       = strength_r;
  assign meas.strength_valid = valid_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strength_r  <= '0;
      valid_r     <= 1'b0;
      last_mean_r <= '0;
    end else begin
      valid_r <= meas.mean_valid;
      if (meas.mean_valid) begin
        strength_r  <= log4(meas.mean); // [R2]
        last_mean_r <= meas.mean;
      end
    end
  end

  property p_saturate;
    @(posedge clk) disable iff (!rst_b)
      (meas.mean_valid && meas.mean[AMP_W-1] && meas.mean[AMP_W-2])
        |=> (valid_r && strength_r == STR_MAX);
  endproperty
  a_saturate: assert property (p_saturate) // [R1]
    else $error("large amplitude did not saturate at the top value");

  property p_floor;
    @(posedge clk) disable iff (!rst_b)
      (meas.mean_valid && meas.mean < 27'h0000002) |=> (strength_r == 7'h00);
  endproperty
  a_floor: assert property (p_floor) // [R2]
    else $error("unit amplitude not converted to zero");

  property p_double_step;
    @(posedge clk) disable iff (!rst_b)
      (meas.mean_valid && last_mean_r != 27'h0000000 && !meas.mean[AMP_W-1]
        && meas.mean == (last_mean_r << 1) && strength_r <= 7'h66)
        |=> (strength_r == 7'($past(strength_r) + 7'h04));
  endproperty
  a_double_step: assert property (p_double_step) // [R3]
    else $error("doubling amplitude did not add four steps");

endmodule

// File: verilog/rsic_top.sv
// Signal strength readout and I/Q trim registers behind an AHB-Lite slave
//
// Notes on behaviour
// R1: Strength is an unsigned 7-bit value held between zero and 106.
// R2: Strength is four times the base-two log of the averaged channel filter amplitude.
// R3: One strength step stands for 1.5 dB of relative power.
// R4: The averaging field selects 2^(field+1) filter samples per strength update.
// R5: The filter clock that paces averaging runs at twice the channel bandwidth.
// R6: Field value 11 averages 16 samples, giving updates at channel bandwidth over 8.
// R7: Software derives absolute power from 1.5 dB per step, three times max gain and an offset.
// R8: Software tunes phase and gain trims to minimise the strength of an image tone.
// R9: Software starts with both estimates zero and step 64, halving the step after pass one.
// R10: Software writes gain first, then phase at +2,+1,0,-1,-2 steps, clamping at 127.
// R11: Software waits 3 ms after a trim write and averages 8 reads 0.5 ms apart; the bench host model waits 400 cycles (4 us) for both.
// R12: Software reads strength no faster than one update period.
// R13: Software repeats from the halving step while the step exceeds one.
// R14: Software forms a curvature term and adds a correction clamped to one step.
// R15: Software mirrors the sweep on gain, then writes both final estimates.
`timescale 1ns/1ps
module rsic_top (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // Channel filter amplitude, sampled on the filter strobe
  input  wire logic [rsic_pkg::AMP_W-1:0]  amp_in,
  // Analog controls and measurement
  output logic [rsic_pkg::TRIM_W-1:0]      phase_estimate,
  output logic [rsic_pkg::TRIM_W-1:0]      gain_estimate,
  output logic [rsic_pkg::GAIN_W-1:0]      amp_gain_cfg_three,
  output logic [rsic_pkg::STR_W-1:0]       strength
);
  import rsic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  addr_r;

  logic        addr_take;
  logic        rd_take;
  logic        wr_cfg;
  logic        wr_phase;
  logic        wr_gain;
  logic        wr_maxgain;
  logic        rd_strength;
  logic [31:0] rd_value;

  // Transfer size is not checked; every access is taken as a whole word
  assign addr_take   = hsel && htrans[1] && hready;
  assign rd_take     = addr_take && !hwrite;
  assign wr_cfg      = wr_pend_r && (addr_r == OFS_CFG);
  assign wr_phase    = wr_pend_r && (addr_r == OFS_PHASE);
  assign wr_gain     = wr_pend_r && (addr_r == OFS_GAIN);
  assign wr_maxgain  = wr_pend_r && (addr_r == OFS_MAXGAIN);
  assign rd_strength = rd_pend_r && (addr_r == OFS_STRENGTH);

  assign hreadyout = hreadyout_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Reads take one wait state so that a write just before is seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout_r <= 1'b1;
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      addr_r      <= 8'h00;
      hrdata_r    <= 32'h00000000;
    end else begin
      hreadyout_r <= !rd_take;
      wr_pend_r   <= addr_take && hwrite;
      rd_pend_r   <= rd_take;
      if (addr_take) begin
        addr_r <= haddr[7:0];
      end
      if (rd_pend_r) begin
        hrdata_r <= rd_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [AVG_W-1:0]  avg_sel_r;
  logic [DIV_W-1:0]  div_sel_r;
  logic [TRIM_W-1:0] phase_r;
  logic [TRIM_W-1:0] gain_r;
  logic [GAIN_W-1:0] maxgain_r;
  logic [STR_W-1:0]  strength_r;
  logic              fresh_r;
  logic [UPD_W-1:0]  updates_r;

  logic [31:0] cfg_word;
  logic [31:0] str_word;

  assign cfg_word = (32'(avg_sel_r) << CFG_AVG_LSB) | (32'(div_sel_r) << CFG_DIV_LSB);
  assign str_word = 32'(strength_r) | (32'(fresh_r) << STR_FRESH_BIT);

  assign rd_value = (addr_r == OFS_CFG)      ? cfg_word :
                    (addr_r == OFS_STRENGTH) ? str_word :
                    (addr_r == OFS_PHASE)    ? 32'(phase_r) :
                    (addr_r == OFS_GAIN)     ? 32'(gain_r) :
                    (addr_r == OFS_MAXGAIN)  ? 32'(maxgain_r) :
                    (addr_r == OFS_UPDATES)  ? 32'(updates_r) :
                    32'h00000000;

  assign phase_estimate     = phase_r;
  assign gain_estimate      = gain_r;
  assign amp_gain_cfg_three = maxgain_r;
  assign strength           = strength_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avg_sel_r <= AVG_RST;
      div_sel_r <= DIV_RST;
      phase_r   <= TRIM_RST;
      gain_r    <= TRIM_RST;
      maxgain_r <= MAXGAIN_RST;
    end else begin
      if (wr_cfg) begin
        avg_sel_r <= hwdata[CFG_AVG_LSB +: AVG_W]; // [R4]
        div_sel_r <= hwdata[CFG_DIV_LSB +: DIV_W]; // [R5]
      end
      // Seven-bit trims hold the full clamped sweep range
      if (wr_phase) begin
        phase_r <= hwdata[TRIM_W-1:0]; // [R8] [R10]
      end
      if (wr_gain) begin
        gain_r <= hwdata[TRIM_W-1:0]; // [R8] [R15]
      end
      if (wr_maxgain) begin
        maxgain_r <= hwdata[GAIN_W-1:0]; // [R7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter rate strobe
  logic filter_tick;

  rsic_tick_gen u_tick (
    .clk         (clk),
    .rst_b       (rst_b),
    .div_sel     (div_sel_r),
    .filter_tick (filter_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Amplitude averaging; a configuration write restarts the run
  logic [3:0]       cnt_r;
  logic [SUM_W-1:0] sum_r;
  logic [AMP_W-1:0] mean_r;
  logic             mean_valid_r;
  logic [SUM_W-1:0] sum_nxt;
  logic             run_end;

  assign sum_nxt = sum_r + {4'h0, amp_in};
  assign run_end = filter_tick && (cnt_r == avg_last(avg_sel_r)); // [R4] [R6]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r        <= 4'h0;
      sum_r        <= '0;
      mean_r       <= '0;
      mean_valid_r <= 1'b0;
    end else begin
      mean_valid_r <= run_end && !wr_cfg;
      if (wr_cfg) begin
        cnt_r <= 4'h0;
        sum_r <= '0;
      end else if (run_end) begin
        cnt_r  <= 4'h0;
        sum_r  <= '0;
        mean_r <= AMP_W'(sum_nxt >> ({1'b0, avg_sel_r} + 3'h1)); // [R4] [R6]
      end else if (filter_tick) begin
        cnt_r <= cnt_r + 4'h1;
        sum_r <= sum_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Log conversion and strength register
  rsic_meas_if meas ();

  assign meas.mean       = mean_r;
  assign meas.mean_valid = mean_valid_r;

  rsic_log4 u_log (
    .clk   (clk),
    .rst_b (rst_b),
    .meas  (meas)
  );

  // Fresh flag: a new value wins over the clear by a strength read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strength_r <= '0;
      fresh_r    <= 1'b0;
      updates_r  <= '0;
    end else begin
      if (meas.strength_valid) begin
        strength_r <= meas.strength; // [R1] [R2]
        updates_r  <= updates_r + 16'h0001;
      end
      fresh_r <= meas.strength_valid || (fresh_r && !rd_strength); // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [4:0] ticks_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ticks_r <= 5'h00;
    end else if (wr_cfg || mean_valid_r) begin
      ticks_r <= 5'h00;
    end else if (filter_tick) begin
      ticks_r <= ticks_r + 5'h01;
    end
  end

  property p_avg_count;
    @(posedge clk) disable iff (!rst_b)
      mean_valid_r |-> (ticks_r == {1'b0, avg_last(avg_sel_r)} + 5'h01);
  endproperty
  a_avg_count: assert property (p_avg_count) // [R4]
    else $error("update not after the selected number of samples");

  property p_avg16;
    @(posedge clk) disable iff (!rst_b)
      (mean_valid_r && avg_sel_r == 2'h3) |-> (ticks_r == 5'h10);
  endproperty
  a_avg16: assert property (p_avg16) // [R6]
    else $error("top averaging setting did not use 16 samples");

  property p_str_max;
    @(posedge clk) disable iff (!rst_b)
      strength_r <= STR_MAX;
  endproperty
  a_str_max: assert property (p_str_max) // [R1]
    else $error("strength above top of range");

  property p_update_path;
    @(posedge clk) disable iff (!rst_b)
      mean_valid_r |=> ##1 (fresh_r && strength_r == $past(meas.strength));
  endproperty
  a_update_path: assert property (p_update_path) // [R2]
    else $error("converted strength not stored with fresh flag");

  property p_rd_wait;
    @(posedge clk) disable iff (!rst_b)
      rd_take |=> (!hreadyout ##1 hreadyout);
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state not exactly one cycle");

  property p_rd_strength;
    @(posedge clk) disable iff (!rst_b)
      rd_strength |=> (hrdata[STR_W-1:0] == $past(strength_r));
  endproperty
  a_rd_strength: assert property (p_rd_strength) // [R12]
    else $error("strength read returned wrong value");

  property p_trim_wr;
    @(posedge clk) disable iff (!rst_b)
      wr_phase |=> (phase_estimate == $past(hwdata[TRIM_W-1:0]));
  endproperty
  a_trim_wr: assert property (p_trim_wr) // [R8]
    else $error("phase trim write not applied");

  property p_gain_wr;
    @(posedge clk) disable iff (!rst_b)
      wr_gain |=> (gain_estimate == $past(hwdata[TRIM_W-1:0]));
  endproperty
  a_gain_wr: assert property (p_gain_wr) // [R8]
    else $error("gain trim write not applied");

  property p_maxgain_wr;
    @(posedge clk) disable iff (!rst_b)
      wr_maxgain |=> (amp_gain_cfg_three == $past(hwdata[GAIN_W-1:0]));
  endproperty
  a_maxgain_wr: assert property (p_maxgain_wr) // [R7]
    else $error("max gain write not applied");

  property p_fresh_clear;
    @(posedge clk) disable iff (!rst_b)
      (rd_strength && !meas.strength_valid) |=> !fresh_r;
  endproperty
  a_fresh_clear: assert property (p_fresh_clear) // [R12]
    else $error("strength read did not clear the fresh flag");

endmodule

// File: tb/rsic_host_model.sv
// Host side model: AHB-Lite master and image calibration sweep
`timescale 1ns/1ps
module rsic_host_model #(
  parameter int SETTLE_CYC  = 400,
  parameter int SPACING_CYC = 400
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AHB-Lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Stuck bus flag
  output logic             bus_hang
);
  import rsic_pkg::*;
  localparam int WAIT_MAX = 64;

  initial begin
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0;
    bus_hang = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single word transfer, waits on hready in both phases
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd);
    int   w;
    logic rdy;
    w = 0;
    rd = 32'h0;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(negedge clk);
      rdy = hready;
      @(posedge clk);
      w++;
    end while (rdy !== 1'b1 && w < WAIT_MAX);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk);
      rdy = hready;
      rd  = hrdata;
      @(posedge clk);
      w++;
    end while (rdy !== 1'b1 && w < WAIT_MAX);
    // Stale data must not look valid
    hwdata <= ~wd;
    if (w >= WAIT_MAX) bus_hang <= 1'b1;
  endtask

  task automatic bus_write(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, ofs, d, unused);
  endtask

  task automatic bus_read(input logic [7:0] ofs, output logic [31:0] d);
    xfer(1'b0, ofs, 32'h0, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Averaged strength sample after a trim write
  task automatic measure(output logic [STR_W-1:0] avg);
    logic [31:0] rd;
    logic [9:0]  sum;
    sum = 10'h000;
    repeat (SETTLE_CYC) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      bus_read(OFS_STRENGTH, rd);
      sum = sum + 10'(rd[STR_W-1:0]);
      repeat (SPACING_CYC) @(posedge clk);
    end
    avg = STR_W'(sum >> 3);
  endtask

  // Phase sweep around an estimate, gain written first
  task automatic sweep(input int est, input int step, input logic [TRIM_W-1:0] gain,
                       output logic [4:0][STR_W-1:0] y);
    int v;
    bus_write(OFS_GAIN, {25'h0, gain});
    for (int k = 2; k >= -2; k--) begin
      v = est + k * step;
      if (v > 127) v = 127;
      if (v < 0) v = 0;
      bus_write(OFS_PHASE, 32'(v));
      measure(y[k+2]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Estimate after a sweep: curvature-weighted step, clamped to one step
  function automatic int refine(input logic [4:0][STR_W-1:0] y, input int est,
                                input int step);
    int a;
    int n;
    int d;
    a = 2 * (int'(y[0]) - int'(y[2]) + int'(y[4])) - int'(y[1]) - int'(y[3]);
    n = 2 * (int'(y[0]) - int'(y[4])) + int'(y[1]) - int'(y[3]);
    if (a > 0) d = (7 * step * n) / (10 * a);
    else d = (int'(y[0]) + int'(y[1]) > int'(y[3]) + int'(y[4])) ? step : -step;
    if (d > step) d = step;
    if (d < -step) d = -step;
    return est + d;
  endfunction
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the strength readout block
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp); \
  end \
end
module tb_top;
  import rsic_pkg::*;
  localparam int LIMIT = 95000;
  // Clock, reset and bus
  logic              clk;
  logic              rst_b;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  // Measurement and controls
  logic [AMP_W-1:0]  amp_in;
  logic [TRIM_W-1:0] phase_estimate;
  logic [TRIM_W-1:0] gain_estimate;
  logic [GAIN_W-1:0] amp_gain_cfg_three;
  logic [STR_W-1:0]  strength;
  logic [6:0]        seen [$];
  int                mismatches;
  int                n_checks;
  int                cyc;

  rsic_top rsic_top_i (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .amp_in(amp_in),
    .phase_estimate(phase_estimate), .gain_estimate(gain_estimate),
    .amp_gain_cfg_three(amp_gain_cfg_three), .strength(strength)
  );

  rsic_host_model #(.SETTLE_CYC(400), .SPACING_CYC(400)) rsic_host_model_i (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .bus_hang()
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(phase_estimate) seen.push_back(phase_estimate);

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Four times log2 with two fraction bits, clamped
  function automatic logic [6:0] exp_str(input logic [26:0] m);
    int p;
    int v;
    if (m < 27'h2) return 7'h00;
    p = 0;
    for (int i = 0; i < 27; i++) if (m[i]) p = i;
    v = 4 * p + ((p == 1) ? 2 * int'(m[0]) : int'((m >> (p - 2)) & 27'h3));
    return (v > 106) ? 7'h6a : 7'(v);
  endfunction

  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    rsic_host_model_i.bus_read(ofs, d);
    `CHK(d, exp, msg)
  endtask

  task automatic wait_update(output logic [31:0] now);
    logic [31:0] start;
    int          i;
    rsic_host_model_i.bus_read(OFS_UPDATES, start);
    now = start;
    i = 0;
    while (now === start && i < 5000) begin
      rsic_host_model_i.bus_read(OFS_UPDATES, now);
      i++;
    end
  endtask

  // Updates over four and a half periods after a sync
  task automatic upd_rate(input logic [1:0] avg, input logic [4:0] div);
    longint      w;
    logic [31:0] a;
    logic [31:0] b;
    rsic_host_model_i.bus_write(OFS_CFG, {19'h0, div, 6'h0, avg});
    // Filter clock is twice a bandwidth of 307.2 kHz over (div+1)
    w = (longint'(9) * CLK_HZ * (longint'(2) << avg) * (div + 1)) / (2 * 2 * 307_200);
    wait_update(a);
    repeat (w) @(posedge clk);
    rsic_host_model_i.bus_read(OFS_UPDATES, b);
    `CHK(b - a, 32'h4, "update count")
  endtask

  task automatic tally_and_finish();
    if (rsic_host_model_i.bus_hang === 1'b1) mismatches++;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0]             a;
    logic [4:0][STR_W-1:0]   y;
    logic [26:0]             amps [5];
    amps = '{27'h0, 27'h5, 27'h600, 27'h1000, 27'h7ffffff};
    rst_b = 1'b0;
    amp_in = 27'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(strength, 7'h00, "strength reset")
    `CHK({phase_estimate, gain_estimate, amp_gain_cfg_three}, 19'h0, "trim reset")
    for (int o = 0; o < 7; o++) rd_chk(8'(4 * o), 32'h0, "reset value");
    rsic_host_model_i.bus_write(OFS_PHASE, 32'hffffffff);
    rd_chk(OFS_PHASE, 32'h7f, "phase field");
    rsic_host_model_i.bus_write(OFS_MAXGAIN, 32'hffffffff);
    rd_chk(OFS_MAXGAIN, 32'h1f, "max gain field");
    `CHK(amp_gain_cfg_three, 5'h1f, "max gain port")
    rsic_host_model_i.bus_write(OFS_GAIN, 32'h55);
    #1;
    `CHK(gain_estimate, 7'h55, "gain port")
    rsic_host_model_i.bus_write(8'h18, 32'hffffffff);
    rd_chk(8'h18, 32'h0, "unmapped");
    rsic_host_model_i.bus_write(OFS_CFG, 32'hffffffff);
    rd_chk(OFS_CFG, 32'h1f03, "cfg fields");
    `CHK(hresp, 1'b0, "okay response")
    $display("test registers done");
    for (int s = 0; s < 5; s++) begin
      upd_rate((s < 4) ? 2'(s) : 2'h0, (s < 4) ? 5'h00 : 5'h03);
    end
    $display("test rate done");
    rsic_host_model_i.bus_write(OFS_CFG, 32'h0);
    foreach (amps[i]) begin
      amp_in <= amps[i];
      wait_update(a);
      wait_update(a);
      #1;
      `CHK(strength, exp_str(amps[i]), "strength port")
      rd_chk(OFS_STRENGTH, {24'h0, 1'b1, exp_str(amps[i])}, "fresh strength");
      rd_chk(OFS_STRENGTH, {24'h0, 1'b0, exp_str(amps[i])}, "fresh cleared");
    end
    $display("test strength done");
    amp_in <= 27'h600;
    rsic_host_model_i.bus_write(OFS_PHASE, 32'h0);
    wait_update(a);
    wait_update(a);
    seen.delete();
    rsic_host_model_i.sweep(0, 64, 7'h00, y);
    `CHK(y, {5{7'h2a}}, "sweep samples")
    `CHK(gain_estimate, 7'h00, "sweep gain")
    `CHK(seen.size(), 3, "phase steps")
    `CHK({seen[0], seen[1], seen[2]}, {7'h7f, 7'h40, 7'h00}, "phase order")
    `CHK(rsic_host_model_i.refine(y, 0, 64), -64, "flat correction")
    y = {7'h32, 7'h28, 7'h1e, 7'h28, 7'h3c};
    `CHK(rsic_host_model_i.refine(y, 5, 64), 16, "curved correction")
    y = {7'h0a, 7'h00, 7'h1e, 7'h14, 7'h28};
    `CHK(rsic_host_model_i.refine(y, 0, 64), 64, "clamped correction")
    $display("test sweep done");
    rsic_host_model_i.bus_write(OFS_CFG, 32'h3);
    wait_update(a);
    wait_update(a);
    rd_chk(OFS_STRENGTH, 32'haa, "avg16 strength");
    $display("test avg16 done");
    tally_and_finish();
  end
endmodule
